// [core/tac_alarm_cmds.sv]
// theft alarm command decoder with flag, state moves and register port
// What this block does
// - update command: code, one value bit, handle, crc; value sets or clears flag
// - update acts only when secured with valid handle; else silent, arbitrate-type with good crc go arbitrate
// - flag set and query arrives with full preamble: send alarm code at once, no round needed
// - flag also set by writing its configuration bit directly
// - query answered only in ready; tag stays in ready
// - flag clear means no reply to query
// - query: code, inverted code, DR, M, TRext, crc
// - DR zero picks divide 8, one picks 64/3
// - M picks 1, 2, 4 or 8 cycles per symbol
// - TRext one prepends a pilot tone to reply preamble
// - query loads crc-5 register with 01001 before code goes out
// - alarm reply is a zero header then fixed 64-bit code
// - update reply is zero header, handle, crc-16 over both
// - update ignored on zero password, bad crc or bad handle; state kept except in arbitrate-type states with good crc
// - update reply always uses extended preamble
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/100ps
module tac_alarm_cmds #(
    parameter logic [63:0] ALARM_CODE = tac_pkg::TAC_ALARM_CODE
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        rx_sof,
    input  wire logic        rx_full_pre,
    input  wire logic        rx_valid,
    input  wire logic        rx_bit,
    input  wire logic        rx_eof,
    input  wire logic [2:0]  tag_state,
    input  wire logic [15:0] cur_handle,
    input  wire logic        apwd_zero,
    input  wire logic        round_dr,
    input  wire logic [1:0]  round_m,
    input  wire logic        nv_flag,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata_q,
    output logic             theft_alarm_flag_q,
    output logic             nv_wr_q,
    output logic [2:0]       st_next_q,
    output logic             st_load_q,
    output logic [4:0]       crc5_q,
    output logic             crc5_load_q,
    output logic             tx_valid_q,
    output logic             tx_bit_q,
    output logic             tx_last_q,
    output logic             tx_pilot_q,
    output logic             tx_dr_q,
    output logic [1:0]       tx_m_q
);
    tac_tx_if txi ();

    tac_pkg::tac_ms_t ms_q;
    logic [55:0]      sr_q;
    logic [5:0]       cnt_q;
    logic [15:0]      rcrc_q;
    logic             pre_q;
    logic             init_q;
    logic             start_q;
    logic             kind_q;
    logic [15:0]      handle_q;
    logic             dr_q;
    logic [1:0]       m_q;
    logic             pilot_q;
    logic [15:0]      almcnt_q;
    logic [15:0]      updcnt_q;
    logic             last_ok_q;

    logic             crc_ok;
    logic             is_upd;
    logic             is_qry;
    logic             upd_val;
    logic [15:0]      upd_handle;
    logic             arb_type;
    logic             upd_go;
    logic             qry_go;
    logic             to_arb;
    logic             decide;
    tac_pkg::tac_tag_st_t st;

    function automatic logic [15:0] tac_cnt_inc(input logic [15:0] c);
        tac_cnt_inc = (c == 16'hFFFF) ? c : c + 16'h0001;
    endfunction

    assign st         = tac_pkg::tac_tag_st_t'(tag_state);
    assign decide     = rx_eof && (ms_q == tac_pkg::TAC_MS_IDLE);
    assign crc_ok     = (rcrc_q == tac_pkg::TAC_CRC16_RES);
    assign is_upd     = (cnt_q == tac_pkg::TAC_UPD_BITS)
                        && (sr_q[48:33] == tac_pkg::TAC_UPD_CODE);
    assign upd_val    = sr_q[32];
    assign upd_handle = sr_q[31:16];
    assign is_qry     = (cnt_q == tac_pkg::TAC_QRY_BITS)
                        && (sr_q[51:36] == tac_pkg::TAC_QRY_CODE)
                        && (sr_q[35:20] == ~tac_pkg::TAC_QRY_CODE);
    assign arb_type   = (st == tac_pkg::TAC_ST_ARB) || (st == tac_pkg::TAC_ST_REPLY)
                        || (st == tac_pkg::TAC_ST_ACK);
    // zero password or bad crc ignored
    assign upd_go     = decide && is_upd && crc_ok && !apwd_zero
                        && (st == tac_pkg::TAC_ST_SEC) && (upd_handle == cur_handle);
    assign qry_go     = decide && is_qry && crc_ok && pre_q
                        && (st == tac_pkg::TAC_ST_READY) && theft_alarm_flag_q;
    assign to_arb     = decide && crc_ok && arb_type
                        && (is_upd || (is_qry && pre_q));

    // frame receive shift and crc
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sr_q   <= 56'h0;
            cnt_q  <= 6'h00;
            rcrc_q <= tac_pkg::TAC_CRC16_INIT;
            pre_q  <= 1'b0;
        end else if (rx_sof) begin
            sr_q   <= 56'h0;
            cnt_q  <= 6'h00;
            rcrc_q <= tac_pkg::TAC_CRC16_INIT;
            pre_q  <= rx_full_pre;
        end else if (rx_valid) begin
            sr_q   <= {sr_q[54:0], rx_bit};
            cnt_q  <= (cnt_q == 6'h3F) ? cnt_q : cnt_q + 6'h01;
            rcrc_q <= tac_pkg::tac_crc16_step(rcrc_q, rx_bit);
        end
    end

    // sequencing of reply requests
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ms_q     <= tac_pkg::TAC_MS_IDLE;
            start_q  <= 1'b0;
            kind_q   <= 1'b0;
            handle_q <= 16'h0000;
            dr_q     <= 1'b0;
            m_q      <= 2'h0;
            pilot_q  <= 1'b0;
        end else begin
            unique case (ms_q)
                tac_pkg::TAC_MS_IDLE: begin
                    if (upd_go) begin
                        start_q  <= 1'b1;
                        kind_q   <= 1'b0;
                        handle_q <= upd_handle;
                        dr_q     <= round_dr;
                        m_q      <= round_m;
                        pilot_q  <= 1'b1;
                        ms_q     <= tac_pkg::TAC_MS_ARM;
                    end else if (qry_go) begin
                        start_q  <= 1'b1;
                        kind_q   <= 1'b1;
                        dr_q     <= sr_q[19];
                        m_q      <= sr_q[18:17];
                        pilot_q  <= sr_q[16];
                        ms_q     <= tac_pkg::TAC_MS_ARM;
                    end
                end
                tac_pkg::TAC_MS_ARM: begin
                    start_q <= 1'b0;
                    ms_q    <= tac_pkg::TAC_MS_REPLY;
                end
                tac_pkg::TAC_MS_REPLY: begin
                    if (!txi.busy) begin
                        ms_q <= tac_pkg::TAC_MS_IDLE;
                    end
                end
                default: begin
                    start_q <= 1'b0;
                    ms_q    <= tac_pkg::TAC_MS_IDLE;
                end
            endcase
        end
    end

    assign txi.start      = start_q;
    assign txi.kind_alarm = kind_q;
    assign txi.handle     = handle_q;
    assign txi.dr         = dr_q;
    assign txi.m          = m_q;
    assign txi.pilot      = pilot_q;

    // tag state move requests
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_next_q <= tac_pkg::TAC_ST_READY;
            st_load_q <= 1'b0;
        end else begin
            st_load_q <= to_arb;
            if (to_arb) begin
                st_next_q <= tac_pkg::TAC_ST_ARB;
            end
        end
    end

    // crc-5 preload for alarm reply
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            crc5_q      <= 5'h00;
            crc5_load_q <= 1'b0;
        end else begin
            crc5_load_q <= qry_go;
            if (qry_go) begin
                crc5_q <= tac_pkg::TAC_CRC5_PRESET;
            end
        end
    end

    // theft alarm flag and its nonvolatile copy
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            theft_alarm_flag_q <= tac_pkg::TAC_FLAG_RST;
            init_q             <= 1'b0;
            nv_wr_q            <= 1'b0;
        end else if (!init_q) begin
            theft_alarm_flag_q <= nv_flag;
            init_q             <= 1'b1;
            nv_wr_q            <= 1'b0;
        end else if (upd_go) begin
            // update wins over same-cycle register write
            // value bit sets or clears
            theft_alarm_flag_q <= upd_val;
            nv_wr_q            <= 1'b1;
        end else if (reg_wr && reg_addr == tac_pkg::TAC_CTRL_IDX) begin
            theft_alarm_flag_q <= reg_wdata[tac_pkg::TAC_CTRL_FLAG];
            nv_wr_q            <= 1'b1;
        end else begin
            nv_wr_q <= 1'b0;
        end
    end

    // reply counters and last result
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            almcnt_q  <= 16'h0000;
            updcnt_q  <= 16'h0000;
            last_ok_q <= 1'b0;
        end else begin
            if (qry_go) begin
                almcnt_q <= tac_cnt_inc(almcnt_q);
            end
            if (upd_go) begin
                updcnt_q <= tac_cnt_inc(updcnt_q);
            end
            if (decide && (is_upd || is_qry)) begin
                last_ok_q <= upd_go || qry_go;
            end
        end
    end

    // register read port
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                tac_pkg::TAC_CTRL_IDX:   reg_rdata_q <= {31'h0, theft_alarm_flag_q};
                tac_pkg::TAC_STAT_IDX:   reg_rdata_q <= {26'h0, last_ok_q, txi.busy,
                                                         ms_q, 1'b0,
                                                         theft_alarm_flag_q};
                tac_pkg::TAC_ALMCNT_IDX: reg_rdata_q <= {16'h0, almcnt_q};
                tac_pkg::TAC_UPDCNT_IDX: reg_rdata_q <= {16'h0, updcnt_q};
                default:                 reg_rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_q <= 32'h0000_0000;
        end
    end

    tac_reply_gen #(
        .ALARM_CODE (ALARM_CODE)
    ) u_gen (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .tx         (txi.gen),
        .tx_valid_q (tx_valid_q),
        .tx_bit_q   (tx_bit_q),
        .tx_last_q  (tx_last_q),
        .tx_pilot_q (tx_pilot_q),
        .tx_dr_q    (tx_dr_q),
        .tx_m_q     (tx_m_q)
    );
endmodule // tac_alarm_cmds

// [core/tac_reply_gen.sv]
// reply serialiser: header bit, alarm code or handle plus crc-16
`timescale 1ns/100ps
module tac_reply_gen #(
    parameter logic [63:0] ALARM_CODE = tac_pkg::TAC_ALARM_CODE
) (
    input  wire logic   sys_clk,
    input  wire logic   rst,
    tac_tx_if.gen       tx,
    output logic        tx_valid_q,
    output logic        tx_bit_q,
    output logic        tx_last_q,
    output logic        tx_pilot_q,
    output logic        tx_dr_q,
    output logic [1:0]  tx_m_q
);
    logic [64:0] sr_q;
    logic [6:0]  left_q;
    logic        busy_q;
    logic [15:0] crc_c;
    logic [16:0] hdr_c;

    // crc over zero header and handle, sent inverted
    always_comb begin
        hdr_c = {1'b0, tx.handle};
        crc_c = tac_pkg::TAC_CRC16_INIT;
        for (int i = 16; i >= 0; i--) begin
            crc_c = tac_pkg::tac_crc16_step(crc_c, hdr_c[i]);
        end
    end

    assign tx.busy = busy_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sr_q       <= 65'h0;
            left_q     <= 7'h00;
            busy_q     <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_bit_q   <= 1'b0;
            tx_last_q  <= 1'b0;
            tx_pilot_q <= 1'b0;
            tx_dr_q    <= 1'b0;
            tx_m_q     <= 2'h0;
        end else if (tx.start && !busy_q) begin
            busy_q     <= 1'b1;
            tx_valid_q <= 1'b0;
            tx_last_q  <= 1'b0;
            tx_pilot_q <= tx.pilot;
            tx_dr_q    <= tx.dr;
            tx_m_q     <= tx.m;
            if (tx.kind_alarm) begin
                sr_q   <= {1'b0, ALARM_CODE};
                left_q <= tac_pkg::TAC_ALM_LEN;
            end else begin
                sr_q   <= {1'b0, tx.handle, ~crc_c, 32'h0000_0000};
                left_q <= tac_pkg::TAC_UPD_LEN;
            end
        end else if (busy_q) begin
            if (left_q == 7'h00) begin
                busy_q     <= 1'b0;
                tx_valid_q <= 1'b0;
                tx_last_q  <= 1'b0;
            end else begin
                tx_valid_q <= 1'b1;
                tx_bit_q   <= sr_q[64];
                tx_last_q  <= (left_q == 7'h01);
                sr_q       <= {sr_q[63:0], 1'b0};
                left_q     <= left_q - 7'h01;
            end
        end else begin
            tx_valid_q <= 1'b0;
            tx_last_q  <= 1'b0;
        end
    end
endmodule // tac_reply_gen

// [pkg/tac_pkg.sv]
// constants, types and crc step shared by the alarm command block
package tac_pkg;
    localparam logic [15:0] TAC_UPD_CODE    = 16'hE003;
    localparam logic [15:0] TAC_QRY_CODE    = 16'hE004;
    localparam logic [5:0]  TAC_UPD_BITS    = 6'h31;
    localparam logic [5:0]  TAC_QRY_BITS    = 6'h34;
    localparam logic [15:0] TAC_CRC16_INIT  = 16'hFFFF;
    localparam logic [15:0] TAC_CRC16_RES   = 16'h1D0F;
    localparam logic [15:0] TAC_CRC16_POLY  = 16'h1021;
    localparam logic [4:0]  TAC_CRC5_PRESET = 5'h09;
    localparam logic [6:0]  TAC_ALM_LEN     = 7'h41;
    localparam logic [6:0]  TAC_UPD_LEN     = 7'h21;
    localparam logic [3:0]  TAC_CTRL_IDX    = 4'h0;
    localparam logic [3:0]  TAC_STAT_IDX    = 4'h1;
    localparam logic [3:0]  TAC_ALMCNT_IDX  = 4'h2;
    localparam logic [3:0]  TAC_UPDCNT_IDX  = 4'h3;
    localparam int          TAC_CTRL_FLAG   = 0;
    localparam logic        TAC_FLAG_RST    = 1'b0;
    localparam logic [63:0] TAC_ALARM_CODE  = 64'h0123_4567_89AB_CDEF;

    typedef enum logic [2:0] {
        TAC_ST_READY = 3'b000,
        TAC_ST_ARB   = 3'b001,
        TAC_ST_REPLY = 3'b010,
        TAC_ST_ACK   = 3'b011,
        TAC_ST_OPEN  = 3'b100,
        TAC_ST_SEC   = 3'b101,
        TAC_ST_KILL  = 3'b110
    } tac_tag_st_t;

    typedef enum logic [1:0] {
        TAC_MS_IDLE  = 2'b00,
        TAC_MS_ARM   = 2'b01,
        TAC_MS_REPLY = 2'b10
    } tac_ms_t;

    function automatic logic [15:0] tac_crc16_step(input logic [15:0] c, input logic b);
        tac_crc16_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? TAC_CRC16_POLY : 16'h0000);
    endfunction
endpackage

// [pkg/tac_tx_if.sv]
// reply request carrier between command decoder and reply serialiser
`timescale 1ns/100ps
interface tac_tx_if;
    logic        start;
    logic        kind_alarm;
    logic [15:0] handle;
    logic        dr;
    logic [1:0]  m;
    logic        pilot;
    logic        busy;
    modport dec (output start, kind_alarm, handle, dr, m, pilot, input busy);
    modport gen (input start, kind_alarm, handle, dr, m, pilot, output busy);
endinterface

// [sim/tac_alarm_cmds_bench.sv]
// self-checking bench for the alarm command block
`timescale 1ns/100ps
module tac_alarm_cmds_bench;
    localparam logic [63:0] CODE = 64'hA5C3_0F96_1E2D_3C4B;
    logic        sys_clk, rst, rx_sof, rx_full_pre, rx_valid, rx_bit, rx_eof, apwd_zero;
    logic        round_dr, nv_flag, reg_wr, reg_rd, theft_alarm_flag_q, nv_wr_q, st_load_q;
    logic        crc5_load_q, tx_valid_q, tx_bit_q, tx_last_q, tx_pilot_q, tx_dr_q, flag_m;
    logic [1:0]  round_m, tx_m_q;
    logic [2:0]  tag_state, st_next_q;
    logic [3:0]  reg_addr;
    logic [4:0]  crc5_q, c5_seen;
    logic [15:0] cur_handle;
    logic [31:0] reg_wdata, reg_rdata_q, v;
    logic        exp_q[$], got[$];
    int          n_ld, n_c5, n_nv, n_lst, n_alm, n_upd, err_total, n_checks, cyc, seed;

    tac_alarm_cmds #(.ALARM_CODE(CODE)) tac_alarm_cmds_inst (.sys_clk, .rst, .rx_sof,
        .rx_full_pre, .rx_valid, .rx_bit, .rx_eof, .tag_state, .cur_handle, .apwd_zero,
        .round_dr, .round_m, .nv_flag, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
        .theft_alarm_flag_q, .nv_wr_q, .st_next_q, .st_load_q, .crc5_q, .crc5_load_q,
        .tx_valid_q, .tx_bit_q, .tx_last_q, .tx_pilot_q, .tx_dr_q, .tx_m_q);
    tac_reader_model tac_reader_model_inst (.sys_clk, .rx_sof, .rx_full_pre, .rx_valid,
        .rx_bit, .rx_eof);

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (tx_valid_q) got.push_back(tx_bit_q);
        if (tx_valid_q && tx_last_q) n_lst = got.size();
        if (st_load_q) n_ld++;
        if (nv_wr_q) n_nv++;
        if (crc5_load_q) begin
            n_c5++;
            c5_seen = crc5_q;
        end
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] want);
        n_checks++;
        if (seen !== want) begin
            err_total++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    function automatic logic rb();
        return 1'($random(seed));
    endfunction

    function automatic logic [15:0] crc16(input logic [63:0] b, input int n);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = n - 1; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0);
        return c;
    endfunction

    function automatic logic [4:0] crc5(input logic [63:0] b, input logic [4:0] c);
        for (int i = 63; i >= 0; i--) c = {c[3:0], 1'b0} ^ ((c[4] ^ b[i]) ? 5'h09 : 5'h00);
        return c;
    endfunction

    function automatic logic [63:0] qf(input logic dr, input logic [1:0] m, input logic tr);
        logic [35:0] b;
        b = {tac_pkg::TAC_QRY_CODE, ~tac_pkg::TAC_QRY_CODE, dr, m, tr};
        return {12'h0, b, ~crc16({28'h0, b}, 36)};
    endfunction

    function automatic logic [63:0] uf(input logic val, input logic [15:0] h);
        logic [32:0] b;
        b = {tac_pkg::TAC_UPD_CODE, val, h};
        return {15'h0, b, ~crc16({31'h0, b}, 33)};
    endfunction

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata_q;
    endtask

    task automatic run(input logic [63:0] f, input int n, input logic full, input logic bad);
        logic       q;
        logic [2:0] st;
        logic [15:0] c;
        logic [63:0] gc;
        @(negedge sys_clk);
        q = (n == 52);
        st = tag_state;
        if (bad) f[0] = ~f[0];
        exp_q.delete();
        got.delete();
        {n_ld, n_c5, n_nv, n_lst} = '0;
        if (!bad && st inside {3'h1, 3'h2, 3'h3} && (full || !q)) begin
        end else if (!bad && q && full && st == 3'h0 && flag_m) begin
            n_alm++;
            exp_q.push_back(1'b0);
            for (int i = 63; i >= 0; i--) exp_q.push_back(CODE[i]);
        end else if (!bad && !q && st == 3'h5 && f[31:16] == cur_handle && !apwd_zero) begin
            n_upd++;
            flag_m = f[32];
            c = ~crc16({48'h0, f[31:16]}, 17);
            exp_q.push_back(1'b0);
            for (int i = 31; i >= 0; i--) exp_q.push_back(i > 15 ? f[i] : c[i]);
        end
        tac_reader_model_inst.send(f, n, full, $random(seed) & 3);
        repeat (80) @(posedge sys_clk);
        chk(got.size(), exp_q.size());
        chk(n_lst, exp_q.size());
        for (int i = 0; i < exp_q.size(); i++) chk(got[i], exp_q[i]);
        chk(n_ld, !bad && st inside {3'h1, 3'h2, 3'h3} && (full || !q));
        if (n_ld > 0) chk(st_next_q, 3'h1);
        chk(n_c5, q && exp_q.size() > 0);
        chk(n_nv, !q && exp_q.size() > 0);
        chk(theft_alarm_flag_q, flag_m);
        if (n_c5 > 0)
            chk({c5_seen, tx_dr_q, tx_m_q, tx_pilot_q}, {5'h09, f[19:16]});
        if (n_nv > 0) chk({tx_pilot_q, tx_dr_q, tx_m_q}, {1'b1, round_dr, round_m});
        if (n_c5 > 0 && got.size() == 65) begin
            for (int i = 1; i < 65; i++) gc[64 - i] = got[i];
            chk(crc5(gc, c5_seen), crc5(CODE, 5'h09));
        end
    endtask

    initial begin
        seed = 32'h303E5FC2;
        {rst, nv_flag} = 2'h3;
        {apwd_zero, round_dr, reg_wr, reg_rd, round_m, tag_state} = '0;
        {reg_addr, reg_wdata, cur_handle} = '0;
        {n_ld, n_c5, n_nv, n_lst, n_alm, n_upd, err_total, n_checks, cyc} = '0;
        repeat (12) @(posedge sys_clk);
        rst        <= 1'b0;
        cur_handle <= 16'($random(seed));
        round_dr   <= rb();
        round_m    <= 2'($random(seed));
        repeat (2) @(posedge sys_clk);
        flag_m = 1'b1;
        chk(theft_alarm_flag_q, flag_m);
        for (int i = 0; i < 4; i++) run(qf(rb(), 2'(i), rb()), 52, 1'b1, 1'b0);
        run(qf(1'b1, 2'h1, 1'b0), 52, 1'b0, 1'b0);
        run(qf(1'b0, 2'h0, 1'b1), 52, 1'b1, 1'b1);
        $display("test query in ready done");
        for (int s = 1; s < 7; s++) begin
            tag_state <= 3'(s);
            run(qf(rb(), 2'h3, rb()), 52, 1'b1, 1'b0);
        end
        $display("test query in other states done");
        tag_state <= 3'h0;
        run(uf(1'b0, cur_handle), 49, 1'b0, 1'b0);
        tag_state <= 3'h2;
        run(uf(1'b0, cur_handle), 49, 1'b0, 1'b0);
        tag_state <= 3'h5;
        run(uf(1'b0, ~cur_handle), 49, 1'b0, 1'b0);
        apwd_zero <= 1'b1;
        run(uf(1'b0, cur_handle), 49, 1'b0, 1'b0);
        apwd_zero <= 1'b0;
        run(uf(1'b0, cur_handle), 49, 1'b0, 1'b1);
        run(uf(1'b0, cur_handle), 49, 1'b0, 1'b0);
        tag_state <= 3'h0;
        run(qf(1'b0, 2'h0, 1'b0), 52, 1'b1, 1'b0);
        $display("test update done");
        v = $random(seed);
        wr(4'h0, v | 32'h1);
        flag_m = 1'b1;
        rd(4'h0, v);
        chk(v[0], 1'b1);
        rd(4'h1, v);
        chk(v, 32'h1);
        rd(4'h9, v);
        chk(v, 32'h0);
        @(posedge sys_clk);
        chk(reg_rdata_q, 32'h0);
        rd(4'h2, v);
        chk(v, n_alm);
        rd(4'h3, v);
        chk(v, n_upd);
        run(qf(1'b1, 2'h2, 1'b1), 52, 1'b1, 1'b0);
        tag_state <= 3'h5;
        run(uf(1'b1, cur_handle), 49, 1'b1, 1'b0);
        $display("test register path done");
        wrap_up();
    end
endmodule // tac_alarm_cmds_bench

// [sim/tac_alarm_cmds_sva.sv]
// port assertions for the alarm command block
`timescale 1ns/100ps
module tac_alarm_cmds_sva (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        rx_eof,
    input wire logic [2:0]  tag_state,
    input wire logic [3:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata_q,
    input wire logic        theft_alarm_flag_q,
    input wire logic        nv_wr_q,
    input wire logic [2:0]  st_next_q,
    input wire logic        st_load_q,
    input wire logic [4:0]  crc5_q,
    input wire logic        crc5_load_q,
    input wire logic        tx_valid_q,
    input wire logic        tx_bit_q,
    input wire logic        tx_last_q,
    input wire logic        tx_pilot_q,
    input wire logic        tx_dr_q,
    input wire logic [1:0]  tx_m_q
);
    logic [6:0] bits_q;
    logic       alm_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // bits sent so far in the current reply
    always_ff @(posedge sys_clk) begin
        if (rst || !tx_valid_q) begin
            bits_q <= 7'h00;
        end else begin
            bits_q <= bits_q + 7'h01;
        end
    end

    // kind of the reply under way
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            alm_q <= 1'b0;
        end else if (crc5_load_q) begin
            alm_q <= 1'b1;
        end else if (nv_wr_q && $past(rx_eof)) begin
            alm_q <= 1'b0;
        end
    end

    a_crc5_preset: assert property (crc5_load_q |-> crc5_q == 5'h09)
        else $error("crc-5 preset wrong");
    a_alarm_start: assert property (crc5_load_q |=> !crc5_load_q
        ##1 (tx_valid_q && !tx_bit_q))
        else $error("alarm reply start wrong");
    a_alarm_gate: assert property (crc5_load_q |-> $past(rx_eof)
        && $past(tag_state) == 3'h0 && $past(theft_alarm_flag_q))
        else $error("alarm reply without cause");
    a_reply_len: assert property (tx_last_q |-> bits_q == (alm_q ? 7'h40 : 7'h20))
        else $error("reply length wrong");
    a_upd_start: assert property (nv_wr_q && $past(rx_eof) |=> tx_pilot_q
        ##1 (tx_valid_q && !tx_bit_q))
        else $error("update reply start wrong");
    a_stload_arb: assert property (st_load_q |-> st_next_q == 3'h1 && $past(rx_eof)
        && $past(tag_state) inside {3'h1, 3'h2, 3'h3})
        else $error("state move wrong");
    a_flag_cause: assert property ($changed(theft_alarm_flag_q) && !$past(rst, 2)
        |-> nv_wr_q || ($past(reg_wr) && $past(reg_addr) == 4'h0))
        else $error("flag changed without cause");
    a_settings_hold: assert property (tx_valid_q |-> $stable(tx_pilot_q)
        && $stable(tx_dr_q) && $stable(tx_m_q))
        else $error("link settings moved in reply");
    a_rd_unmapped: assert property (reg_rd && reg_addr > 4'h3 |=> reg_rdata_q == 32'h0)
        else $error("unmapped read not zero");
    a_rd_once: assert property (reg_rd ##1 !reg_rd |=> reg_rdata_q == 32'h0)
        else $error("read data held too long");
endmodule // tac_alarm_cmds_sva

bind tac_alarm_cmds tac_alarm_cmds_sva tac_alarm_cmds_sva_inst (.sys_clk, .rst, .rx_eof,
    .tag_state, .reg_addr, .reg_wr, .reg_rd, .reg_rdata_q, .theft_alarm_flag_q, .nv_wr_q,
    .st_next_q, .st_load_q, .crc5_q, .crc5_load_q, .tx_valid_q, .tx_bit_q, .tx_last_q,
    .tx_pilot_q, .tx_dr_q, .tx_m_q);

// [sim/tac_reader_model.sv]
// interrogator model sending command frames bit by bit
`timescale 1ns/100ps
module tac_reader_model (
    input  wire logic sys_clk,
    output logic      rx_sof,
    output logic      rx_full_pre,
    output logic      rx_valid,
    output logic      rx_bit,
    output logic      rx_eof
);
    initial begin
        rx_sof      = 1'b0;
        rx_full_pre = 1'b0;
        rx_valid    = 1'b0;
        rx_bit      = 1'b1;
        rx_eof      = 1'b0;
    end

    task automatic send(input logic [63:0] f, input int n, input logic full, input int gap);
        @(posedge sys_clk);
        // preamble kind given at frame start
        rx_sof      <= 1'b1;
        rx_full_pre <= full;
        @(posedge sys_clk);
        rx_sof <= 1'b0;
        // frame bits first to last, idle gaps between
        for (int i = n - 1; i >= 0; i--) begin
            rx_valid <= 1'b1;
            rx_bit   <= f[i];
            @(posedge sys_clk);
            if (gap > 0) begin
                rx_valid <= 1'b0;
                rx_bit   <= ~f[i];
                repeat (gap) @(posedge sys_clk);
            end
        end
        rx_valid    <= 1'b0;
        rx_bit      <= ~rx_bit;
        rx_full_pre <= ~full;
        rx_eof      <= 1'b1;
        @(posedge sys_clk);
        rx_eof <= 1'b0;
    endtask
endmodule // tac_reader_model
